// ===== hw/down_timer.sv
// Loadable down counter that flags when it reaches zero.
`timescale 1ns/100ps
module down_timer (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Control
	timer_if.timer ctl
);
	logic [31:0] count_reg;
	assign ctl.expired = (count_reg == 32'h0000_0000);
	always_ff @(posedge core_clk) begin
		if (reset)
			count_reg <= 32'h0000_0000;
		else if (ctl.load)
			count_reg <= ctl.count;
		else if (count_reg != 32'h0000_0000)
			count_reg <= count_reg - 32'h0000_0001;
	end
endmodule : down_timer

// ===== hw/lock_qualifier.sv
// Counts consecutive locked bit times of the receive clock recovery.
`timescale 1ns/100ps
`include "link_supervisor_consts.svh"
module lock_qualifier (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Receive clock recovery
	input wire logic rx_active,
	input wire logic pll_locked,
	// Result
	output logic data_valid
);
	logic [7:0] bit_cnt_reg;
	logic [3:0] bits_reg;
	logic bit_tick;
	assign bit_tick = (bit_cnt_reg == 8'(`BIT_TIME_CYCLES - 1));
	// Lock must hold for three consecutive bit times.
	assign data_valid = (bits_reg >= 4'(`LOCK_BITS_MIN));
	always_ff @(posedge core_clk) begin
		if (reset || !rx_active || !pll_locked) begin
			bit_cnt_reg <= 8'h00;
			bits_reg <= 4'h0;
		end else begin
			bit_cnt_reg <= bit_tick ? 8'h00 : bit_cnt_reg + 8'h01;
			if (bit_tick && bits_reg != 4'hf)
				bits_reg <= bits_reg + 4'h1;
		end
	end
endmodule : lock_qualifier

// ===== hw/tenbase_t_link_supervisor.sv
// 10BASE-T link pulse, link monitor, carrier, collision, jabber, heartbeat.
`timescale 1ns/100ps
`include "link_supervisor_consts.svh"

// Summary of operation
// - Send a link pulse every 16 ms idle.
// - Keep pulsing while receiving a frame.
// - Link status latches low, shown twice.
// - Invalid goes valid on 8 pulses or data.
// - Valid stays while pulses or data arrive.
// - Silence beyond 82 ms drops the link.
// - Valid data needs three locked bit times.
// - Data-qualified link waits for packet end.
// - Going valid does not reset latched flag.
// - Strict inhibit zero demands idle delimiter.
// - Append idle delimiter after each transmit not ended by jabber.
// - Carrier sense per duplex mode.
// - Collision on overlap, never in full duplex.
// - Jabber asserts collision in half duplex, blocks data, pulses continue.
// - Jabber sets a latch-high status flag.
// - Jabber inhibit zero enables jabber detection.
// - Heartbeat collision pulse when transmit enable falls.
// - Heartbeat only node, half duplex, link valid.
// - Clock recovery runs from preamble through data.
module tenbase_t_link_supervisor
	import link_supervisor_pkg::*;
#(
	parameter logic [31:0] LINK_PULSE_CYCLES = 32'(`LINK_PULSE_CYCLES),
	parameter logic [31:0] LINK_FAIL_CYCLES = 32'(`LINK_FAIL_CYCLES),
	parameter logic [31:0] JABBER_LIMIT_CYCLES = 32'(`JABBER_LIMIT_CYCLES),
	parameter logic [31:0] JABBER_UNJAB_CYCLES = 32'(`JABBER_UNJAB_CYCLES),
	parameter logic [31:0] HEARTBEAT_CYCLES = 32'(`HEARTBEAT_CYCLES)
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// Configuration
	input wire logic node_mode,
	// MAC side
	input wire logic tx_en,
	output logic crs,
	output logic col,
	// Receive path from the medium
	input wire logic rx_activity,
	input wire logic rx_preamble,
	input wire logic rx_pll_locked,
	input wire logic rx_idle_delim,
	input wire logic rx_link_pulse,
	output logic rx_pll_enable,
	// Transmit path toward the medium
	output logic tx_data_enable,
	output logic tx_idle_delim,
	output logic tx_link_pulse
);
	logic [15:0] ops_reg;
	logic link_latch_reg;
	logic jabber_latch_reg;
	logic [15:0] rdata_reg;
	link_state_t link_state_reg;
	link_state_t link_state_next;
	tx_state_t tx_state_reg;
	tx_state_t tx_state_next;
	logic [3:0] pulse_cnt_reg;
	logic data_seen_reg;
	logic tx_en_d_reg;
	logic rx_acq_reg;
	logic heartbeat_reg;
	logic pulse_out_reg;
	logic data_valid;
	logic strict_q;
	logic full_duplex;
	logic link_valid;
	logic transmitting;
	logic tx_fall;
	logic rx_end;
	logic data_qualified;
	logic activity_seen;
	logic heartbeat_ok;
	logic jabber_start;
	logic rd_status;
	logic rd_quick;
	logic rd_ops;
	logic rd_link;
	logic wr_ops;
	logic [15:0] rdata_next;

	timer_if pulse_t ();
	timer_if fail_t ();
	timer_if jab_t ();
	timer_if hb_t ();
	timer_if delim_t ();

	down_timer u_pulse (.core_clk(core_clk), .reset(reset), .ctl(pulse_t));
	down_timer u_fail (.core_clk(core_clk), .reset(reset), .ctl(fail_t));
	down_timer u_jab (.core_clk(core_clk), .reset(reset), .ctl(jab_t));
	down_timer u_hb (.core_clk(core_clk), .reset(reset), .ctl(hb_t));
	down_timer u_delim (.core_clk(core_clk), .reset(reset), .ctl(delim_t));

	lock_qualifier u_lock (
		.core_clk(core_clk),
		.reset(reset),
		.rx_active(rx_acq_reg),
		.pll_locked(rx_pll_locked),
		.data_valid(data_valid)
	);

	// Configuration decode.
	assign strict_q = ~ops_reg[`OPS_STRICT_INHIBIT_BIT];
	assign full_duplex = ops_reg[`OPS_FULL_DUPLEX_BIT];
	assign link_valid = (link_state_reg == LINK_VALID);
	assign transmitting = (tx_state_reg == TX_SEND);
	assign tx_fall = tx_en_d_reg & ~tx_en;

	// Clock recovery starts with preamble and runs during data.
	assign rx_pll_enable = rx_acq_reg;
	assign rx_end = rx_acq_reg & ~rx_activity;

	// Data qualifies on packet end, with delimiter if strict.
	assign data_qualified = data_seen_reg & rx_end &
		(~strict_q | rx_idle_delim);
	assign activity_seen = rx_link_pulse | data_qualified;

	// Link pulse generator runs regardless of receive.
	assign pulse_t.load = pulse_t.expired;
	assign pulse_t.count = LINK_PULSE_CYCLES - 32'h0000_0001;
	assign tx_link_pulse = pulse_out_reg;

	// Link fail timer restarts on a link pulse or qualified data.
	assign fail_t.load = activity_seen | ~link_valid;
	assign fail_t.count = LINK_FAIL_CYCLES;

	// Link monitor state machine.
	always_comb begin
		link_state_next = link_state_reg;
		case (link_state_reg)
			LINK_INVALID: begin
				if (pulse_cnt_reg >= 4'(`LINK_PULSE_COUNT_MIN))
					link_state_next = LINK_VALID;
				else if (data_valid)
					link_state_next = LINK_PENDING;
			end
			LINK_PENDING: begin
				if (data_qualified)
					link_state_next = LINK_VALID;
				else if (rx_end)
					link_state_next = LINK_INVALID;
			end
			LINK_VALID: begin
				if (fail_t.expired)
					link_state_next = LINK_INVALID;
			end
			default: link_state_next = LINK_INVALID;
		endcase
	end

	// Jabber timer runs while sending; inhibit bit masks jabber_start.
	assign jabber_start = transmitting & jab_t.expired &
		~ops_reg[`OPS_JABBER_INHIBIT_BIT];
	assign jab_t.load = (tx_state_reg == TX_IDLE && tx_state_next == TX_SEND) |
		jabber_start;
	assign jab_t.count = jabber_start ? JABBER_UNJAB_CYCLES :
		JABBER_LIMIT_CYCLES;

	// Idle delimiter follows every packet that leaves TX_SEND on tx_en low; none after TX_JABBER.
	assign delim_t.load = transmitting & ~tx_en;
	assign delim_t.count = 32'(`IDLE_DELIM_CYCLES);

	// Transmit state machine.
	always_comb begin
		tx_state_next = tx_state_reg;
		case (tx_state_reg)
			TX_IDLE: begin
				if (tx_en)
					tx_state_next = TX_SEND;
			end
			TX_SEND: begin
				if (jabber_start)
					tx_state_next = TX_JABBER;
				else if (!tx_en)
					tx_state_next = TX_DELIM;
			end
			TX_DELIM: begin
				if (delim_t.expired)
					tx_state_next = TX_IDLE;
			end
			TX_JABBER: begin
				if (jab_t.expired && !tx_en)
					tx_state_next = TX_IDLE;
			end
			default: tx_state_next = TX_IDLE;
		endcase
	end

	// Medium drive: jabber blocks data, pulses still go out.
	assign tx_data_enable = transmitting;
	assign tx_idle_delim = (tx_state_reg == TX_DELIM);

	// Heartbeat enable conditions.
	assign heartbeat_ok = node_mode & ~full_duplex & link_valid &
		~ops_reg[`OPS_HEARTBEAT_INHIBIT_BIT];
	assign hb_t.load = tx_fall & heartbeat_ok;
	assign hb_t.count = HEARTBEAT_CYCLES;

	// Carrier sense and collision toward the MAC.
	assign crs = full_duplex ? rx_acq_reg :
		(rx_acq_reg | tx_en);
	assign col = ~full_duplex & ((rx_acq_reg & transmitting) |
		(tx_state_reg == TX_JABBER) | heartbeat_reg);

	// Register decode.
	assign rd_status = reg_read & (reg_addr == `STATUS_OFFSET);
	assign rd_quick = reg_read & (reg_addr == `QUICK_STATUS_OFFSET);
	assign rd_ops = reg_read & (reg_addr == `OPS_OFFSET);
	assign rd_link = rd_status | rd_quick;
	assign wr_ops = reg_write & (reg_addr == `OPS_OFFSET);

	always_comb begin
		rdata_next = 16'h0000;
		if (rd_status)
			rdata_next[`STATUS_LINK_BIT] = link_latch_reg;
		if (rd_quick) begin
			rdata_next[`QUICK_LINK_BIT] = link_latch_reg;
			rdata_next[`QUICK_JABBER_BIT] = jabber_latch_reg;
		end
		if (rd_ops)
			rdata_next = ops_reg;
	end
	assign reg_rdata = rdata_reg;

	// Control and link state.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ops_reg <= `OPS_RESET_VALUE;
			link_state_reg <= LINK_INVALID;
			tx_state_reg <= TX_IDLE;
			rdata_reg <= 16'h0000;
			tx_en_d_reg <= 1'b0;
		end else begin
			if (wr_ops)
				ops_reg <= reg_wdata;
			link_state_reg <= link_state_next;
			tx_state_reg <= tx_state_next;
			rdata_reg <= rdata_next;
			tx_en_d_reg <= tx_en;
		end
	end

	// Latched status flags; a drop wins over the read refresh.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link_latch_reg <= 1'b0;
			jabber_latch_reg <= 1'b0;
		end else begin
			if (link_state_next != LINK_VALID)
				link_latch_reg <= 1'b0;
			else if (rd_link)
				link_latch_reg <= 1'b1;
			if (jabber_start)
				jabber_latch_reg <= 1'b1;
			else if (rd_quick)
				jabber_latch_reg <= 1'b0;
		end
	end

	// Receive tracking, link pulse count and heartbeat output.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rx_acq_reg <= 1'b0;
			data_seen_reg <= 1'b0;
			pulse_cnt_reg <= 4'h0;
			heartbeat_reg <= 1'b0;
			pulse_out_reg <= 1'b0;
		end else begin
			if (rx_preamble)
				rx_acq_reg <= 1'b1;
			else if (!rx_activity)
				rx_acq_reg <= 1'b0;
			if (!rx_acq_reg)
				data_seen_reg <= 1'b0;
			else if (data_valid)
				data_seen_reg <= 1'b1;
			if (link_valid || fail_t.expired && !link_valid &&
				pulse_cnt_reg == 4'h0)
				pulse_cnt_reg <= 4'h0;
			else if (rx_link_pulse && pulse_cnt_reg != 4'hf)
				pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
			heartbeat_reg <= hb_t.load | ~hb_t.expired;
			pulse_out_reg <= pulse_t.expired;
		end
	end
endmodule : tenbase_t_link_supervisor

// ===== shared/link_supervisor_consts.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef LINK_SUPERVISOR_CONSTS_SVH
`define LINK_SUPERVISOR_CONSTS_SVH

`define CLK_FREQ_MHZ 200
`define STATUS_OFFSET 8'h01
`define QUICK_STATUS_OFFSET 8'h11
`define OPS_OFFSET 8'h12
`define STATUS_LINK_BIT 2
`define QUICK_LINK_BIT 0
`define QUICK_JABBER_BIT 2
`define OPS_STRICT_INHIBIT_BIT 0
`define OPS_HEARTBEAT_INHIBIT_BIT 2
`define OPS_JABBER_INHIBIT_BIT 5
`define OPS_FULL_DUPLEX_BIT 8
`define OPS_RESET_VALUE 16'h0000
`define LINK_PULSE_MS 16
`define LINK_PULSE_CYCLES (`LINK_PULSE_MS * 1000 * `CLK_FREQ_MHZ)
`define LINK_FAIL_MS 82
`define LINK_FAIL_CYCLES (`LINK_FAIL_MS * 1000 * `CLK_FREQ_MHZ)
`define LINK_PULSE_COUNT_MIN 8
`define BIT_TIME_NS 100
`define BIT_TIME_CYCLES ((`BIT_TIME_NS * `CLK_FREQ_MHZ) / 1000)
`define LOCK_BITS_MIN 3
`define JABBER_LIMIT_MS 30
`define JABBER_LIMIT_CYCLES (`JABBER_LIMIT_MS * 1000 * `CLK_FREQ_MHZ)
`define JABBER_UNJAB_MS 400
`define JABBER_UNJAB_CYCLES (`JABBER_UNJAB_MS * 1000 * `CLK_FREQ_MHZ)
`define HEARTBEAT_NS 1000
`define HEARTBEAT_CYCLES ((`HEARTBEAT_NS * `CLK_FREQ_MHZ) / 1000)
`define IDLE_DELIM_NS 300
`define IDLE_DELIM_CYCLES ((`IDLE_DELIM_NS * `CLK_FREQ_MHZ) / 1000)

`endif

// ===== shared/link_supervisor_pkg.sv
// Types shared by the link supervisor modules.
package link_supervisor_pkg;
	typedef enum logic [1:0] {
		LINK_INVALID,
		LINK_PENDING,
		LINK_VALID
	} link_state_t;
	typedef enum logic [1:0] {
		TX_IDLE,
		TX_SEND,
		TX_DELIM,
		TX_JABBER
	} tx_state_t;
endpackage : link_supervisor_pkg

// ===== shared/timer_if.sv
// Interface between the supervisor and its down counters.
`timescale 1ns/100ps
interface timer_if;
	logic load;
	logic [31:0] count;
	logic expired;
	modport owner (output load, output count, input expired);
	modport timer (input load, input count, output expired);
endinterface : timer_if

// ===== testbench/medium_model.sv
// Model of the twisted-pair receive side feeding the supervisor.
`timescale 1ns/100ps
module medium_model (
	// Clock
	input wire logic core_clk,
	// Receive indications
	output logic rx_activity = 0,
	output logic rx_preamble = 0,
	output logic rx_pll_locked = 0,
	output logic rx_idle_delim = 0,
	output logic rx_link_pulse = 0
);
	task automatic frame(input int n, input logic d);
		@(posedge core_clk);
		rx_activity <= 1;
		rx_preamble <= 1;
		@(posedge core_clk);
		rx_preamble <= 0;
		rx_pll_locked <= 1;
		repeat (n) @(posedge core_clk);
		rx_idle_delim <= d;
		rx_activity <= 0;
		rx_pll_locked <= 0;
		@(posedge core_clk);
		rx_idle_delim <= 0;
	endtask : frame
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge core_clk);
			rx_link_pulse <= 1;
			@(posedge core_clk);
			rx_link_pulse <= 0;
			repeat (3) @(posedge core_clk);
		end
	endtask : pulses
endmodule : medium_model

// ===== testbench/tenbase_t_link_supervisor_checker.sv
// Port assertions for the link supervisor.
`timescale 1ns/100ps
module tenbase_t_link_supervisor_checker #(
	parameter int JABBER_LIMIT_CYCLES = 100,
	parameter int HEARTBEAT_CYCLES = 20,
	parameter int LINK_PULSE_CYCLES = 50
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	// MAC and medium
	input wire logic tx_en,
	input wire logic crs,
	input wire logic col,
	input wire logic rx_pll_enable,
	input wire logic tx_data_enable,
	input wire logic tx_link_pulse
);
	localparam int P_MAX = LINK_PULSE_CYCLES + 2;
	localparam int HB_LO = HEARTBEAT_CYCLES - 8;
	localparam int HB_HI = HEARTBEAT_CYCLES - 6;
	logic [15:0] ops_reg;
	logic [31:0] run_reg;
	wire logic fd = ops_reg[8];
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	always_ff @(posedge core_clk) begin
		if (reset)
			ops_reg <= 16'h0000;
		else if (reg_write && reg_addr == 8'h12)
			ops_reg <= reg_wdata;
	end
	always_ff @(posedge core_clk) begin
		if (reset || !tx_data_enable)
			run_reg <= 32'h0000_0000;
		else
			run_reg <= run_reg + 32'h0000_0001;
	end
	sequence hb_start;
		$fell(tx_en) && $past(tx_data_enable) ##1 col && !rx_pll_enable;
	endsequence
	AST_FD_COL: assert property (fd |-> !col)
		else $error("col high in full duplex");
	AST_CRS_TX: assert property (!fd && tx_en |-> crs)
		else $error("crs low while sending");
	AST_COL_OVL: assert property (
		!fd && tx_en && rx_pll_enable |-> ##[0:1] col)
		else $error("no col on overlap");
	AST_PULSE: assert property (
		tx_link_pulse |=> !tx_link_pulse ##[1:P_MAX] tx_link_pulse)
		else $error("link pulse missing");
	AST_JAB_BLOCK: assert property (tx_en && $past(tx_en) && !tx_data_enable
		|-> col)
		else $error("blocked data without col");
	AST_JAB_BOUND: assert property (!ops_reg[5]
		|-> run_reg <= JABBER_LIMIT_CYCLES + 2)
		else $error("transmit ran past jabber limit");
	AST_HB: assert property (hb_start |=> col[*8] ##[HB_LO:HB_HI] !col)
		else $error("heartbeat length wrong");
	AST_OPS_RD: assert property (reg_read && reg_addr == 8'h12
		|=> reg_rdata == $past(ops_reg))
		else $error("ops readback wrong");
endmodule : tenbase_t_link_supervisor_checker
bind tenbase_t_link_supervisor tenbase_t_link_supervisor_checker
	chk_i (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
	.reg_rdata, .tx_en, .crs, .col, .rx_pll_enable, .tx_data_enable,
	.tx_link_pulse);

// ===== testbench/tenbase_t_link_supervisor_tb.sv
// Self-checking bench for the link supervisor.
`timescale 1ns/100ps
module tenbase_t_link_supervisor_tb;
	logic core_clk = 0;
	logic reset = 1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_write = 0;
	logic reg_read = 0;
	logic node_mode = 1;
	logic tx_en = 0;
	logic [15:0] reg_rdata, v;
	logic crs, col, rx_activity, rx_preamble, rx_pll_locked, rx_idle_delim;
	logic rx_link_pulse, rx_pll_enable, tx_data_enable, tx_idle_delim;
	logic tx_link_pulse;
	int num_errors = 0;
	int num_checks = 0;
	always #2.5 core_clk = ~core_clk;
	medium_model mm (.core_clk, .rx_activity, .rx_preamble, .rx_pll_locked,
		.rx_idle_delim, .rx_link_pulse);
	tenbase_t_link_supervisor #(.LINK_PULSE_CYCLES(50), .LINK_FAIL_CYCLES(200),
		.JABBER_LIMIT_CYCLES(100), .JABBER_UNJAB_CYCLES(100),
		.HEARTBEAT_CYCLES(20)) uut (.core_clk, .reset, .reg_addr, .reg_wdata,
		.reg_write, .reg_read, .reg_rdata, .node_mode, .tx_en, .crs, .col,
		.rx_activity, .rx_preamble, .rx_pll_locked, .rx_idle_delim,
		.rx_link_pulse, .rx_pll_enable, .tx_data_enable, .tx_idle_delim,
		.tx_link_pulse);
	task automatic test_done;
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic at(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : at
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1;
		@(posedge core_clk);
		reg_write <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1;
		@(posedge core_clk);
		reg_read <= 0;
		#1;
		v = reg_rdata;
	endtask : rd
	task automatic rb(input logic [7:0] a, input int b, input logic e);
		rd(a);
		chk("status bit", 16'(e), 16'(v[b]));
	endtask : rb
	task automatic hb(input logic e);
		mm.pulses(1);
		@(posedge core_clk);
		tx_en <= 1;
		repeat (10) @(posedge core_clk);
		tx_en <= 0;
		at(5);
		chk("heartbeat col", 16'(e), 16'(col));
		chk("tx delimiter", 16'h0001, 16'(tx_idle_delim));
		at(80);
	endtask : hb
	task automatic t_link;
		rd(8'h12);
		chk("ops reset", 16'h0000, v);
		rd(8'h20);
		chk("unmapped", 16'h0000, v);
		rb(8'h11, 0, 0);
		mm.pulses(7);
		rb(8'h01, 2, 0);
		mm.pulses(1);
		at(3);
		rb(8'h01, 2, 0);
		rb(8'h01, 2, 1);
		rb(8'h11, 0, 1);
		at(220);
		rb(8'h11, 0, 0);
		rb(8'h01, 2, 0);
		hb(0);
	endtask : t_link
	task automatic t_data;
		mm.frame(80, 0);
		rb(8'h01, 2, 0);
		rb(8'h01, 2, 0);
		fork
			mm.frame(80, 1);
		join_none
		at(70);
		chk("acquire", 16'h0001, 16'(rx_pll_enable));
		chk("crs rx", 16'h0001, 16'(crs));
		rb(8'h01, 2, 0);
		rb(8'h01, 2, 0);
		at(20);
		rb(8'h01, 2, 0);
		rb(8'h01, 2, 1);
		at(220);
		mm.frame(30, 1);
		rb(8'h01, 2, 0);
		rb(8'h01, 2, 0);
		wr(8'h12, 16'h0001);
		mm.frame(80, 0);
		rb(8'h01, 2, 0);
		rb(8'h01, 2, 1);
		wr(8'h12, 16'h0000);
	endtask : t_data
	task automatic t_heart;
		hb(1);
		wr(8'h12, 16'h0004);
		hb(0);
		wr(8'h12, 16'h0100);
		hb(0);
		wr(8'h12, 16'h0000);
		node_mode <= 0;
		hb(0);
		node_mode <= 1;
	endtask : t_heart
	task automatic t_duplex(input logic [15:0] ops, input logic fd);
		wr(8'h12, ops);
		@(posedge core_clk);
		tx_en <= 1;
		at(3);
		chk("crs tx", 16'(!fd), 16'(crs));
		fork
			mm.frame(80, 1);
		join_none
		at(65);
		chk("crs both", 16'h0001, 16'(crs));
		chk("col both", 16'(!fd), 16'(col));
		@(posedge core_clk);
		tx_en <= 0;
		at(100);
	endtask : t_duplex
	task automatic t_jab(input logic [15:0] ops, input logic inh);
		wr(8'h12, ops);
		@(posedge core_clk);
		tx_en <= 1;
		at(120);
		chk("tx data", 16'(inh), 16'(tx_data_enable));
		chk("jabber col", 16'(!inh), 16'(col));
		rb(8'h11, 2, !inh);
		@(posedge core_clk);
		tx_en <= 0;
		at(150);
	endtask : t_jab
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 0;
		t_link();
		t_data();
		t_heart();
		t_duplex(16'h0000, 0);
		t_duplex(16'h0100, 1);
		t_jab(16'h0000, 0);
		t_jab(16'h0020, 1);
		test_done();
	end
endmodule : tenbase_t_link_supervisor_tb
